// ==== sbd_pkg.sv ====
// package: register map, fields, timing and carriers of the sdram decoder
package sbd_pkg;

    // ==================== register offsets
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h04;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h0c;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;

    // ==================== control register fields
    localparam int BASE_LSB = 18;
    localparam int BASE_W = 14;
    localparam int PS_LSB = 4;
    localparam int PS_WIDE_BIT = 5;
    localparam int TRIG_BIT = 3;
    localparam int PM_BIT = 2;

    // ==================== mask register fields
    localparam int BAM_LSB = 18;
    localparam int WP_BIT = 8;
    localparam int AM_LSB = 1;
    localparam int AM_W = 6;
    localparam int VALID_BIT = 0;

    // ==================== reset values
    localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;

    // ==================== access categories
    localparam logic [2:0] CAT_USER_DATA = 3'h0;
    localparam logic [2:0] CAT_USER_CODE = 3'h1;
    localparam logic [2:0] CAT_SUPV_DATA = 3'h2;
    localparam logic [2:0] CAT_SUPV_CODE = 3'h3;
    localparam logic [2:0] CAT_ALT_MASTER = 3'h4;
    localparam logic [2:0] CAT_CPU_SPACE = 3'h5;

    // ==================== interrupt status bits
    localparam int IRQ_W = 4;
    localparam int IRQ_WP_EXC = 0;
    localparam int IRQ_ACC_EXC = 1;
    localparam int IRQ_PRECHARGE_ALL_COMMAND_DONE = 2;
    localparam int IRQ_BAD_PS = 3;

    // ==================== geometry of the 16-bit port
    localparam int PORT_BYTES = 2;
    localparam int PAGE_LSB = 10;
    localparam int ROW_W = 13;

    // ==================== timing in ns and in cycles
    localparam int CLK_NS = 10;
    localparam int TRCD_CYC = 2;
    localparam int TRP_CYC = 2;
    localparam int EXT_TIMEOUT_NS = 1280;
    localparam int EXT_TIMEOUT_CYC = EXT_TIMEOUT_NS / CLK_NS;
    localparam int CNT_W = 8;

    // request from the internal bus masters
    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [4:0] bytes;      // transfer size in bytes, 1 to 16
        logic [2:0] cat;        // access category
    } sbd_req_type;

    // command lines towards the sdram
    typedef struct packed {
        logic chip_sel_n;
        logic row_strobe_n;
        logic column_strobe_n;
        logic write_en_n;
        logic [ROW_W-1:0] addr;
    } sbd_sdcmd_type;

    localparam sbd_sdcmd_type SD_NOP = '{1'b0, 1'b1, 1'b1, 1'b1, '0};

endpackage : sbd_pkg

// ==== sbd_decode.sv ====
// sdram block decoder: hit decode, write protect, page mode and precharge-all sequencing
// Contract
// - trigger set: next suitable sdram write issues precharge-all; writing 0 does nothing
// - controller clears the trigger bit when it issues the precharge-all command, before the tRP wait
// - page mode 0: burst only within page above port size, then precharge
// - page mode 1: page stays open; same-page accesses use column strobe only
// - each set base-address mask bit drops its address bit from hit compare
// - write protect set: writes ignored and address exception raised
// - protected write goes to chip-select decode; unacknowledged external cycle faults
// - set access-type mask bit keeps that category from hitting
// - port size gives block width; only 16-bit setting is valid
// - six categories: cpu space, alternate master, supv code/data, user code/data
// - block enable cleared at reset; while clear nothing hits
`timescale 1ns/10ps
module sbd_decode (
    input wire logic i_mclk, // system clock, 100 mhz
    input wire logic i_rst, // async reset, active high
    input wire logic [7:0] i_reg_addr, // register byte address
    input wire logic [31:0] i_reg_wdata, // register write data
    input wire logic i_reg_wr, // register write strobe
    input wire logic i_reg_rd, // register read strobe
    output logic [31:0] o_reg_rdata, // read data, cycle after strobe
    input wire logic i_req, // access request pulse
    input wire sbd_pkg::sbd_req_type i_req_data, // access request fields
    output logic o_ready, // idle, may take a request
    output logic o_done, // access finished pulse
    output logic o_hit, // last request hit this block
    output logic o_addr_exc, // address exception pulse
    output logic o_cs_req, // hand write to chip-select decode
    input wire logic i_cs_valid, // chip-select decode answer
    input wire logic i_cs_hit, // a chip select claimed it
    output logic o_ext_cycle, // external bus cycle running
    input wire logic i_ext_ack, // external cycle acknowledged
    output logic o_access_exc, // access exception pulse
    output sbd_pkg::sbd_sdcmd_type o_sd_cmd, // sdram command lines
    output logic o_irq // level interrupt
);
    import sbd_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_PRE, ST_ACT, ST_COL, ST_WAIT, ST_PRECHARGE_ALL_COMMAND, ST_CS_WAIT, ST_EXT, ST_FIN
    } sbd_state_type;

    // ==================== register state
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] mask_r, mask_nxt;
    logic [IRQ_W-1:0] stat_r, stat_nxt;
    logic [IRQ_W-1:0] ien_r, ien_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    logic [IRQ_W-1:0] ev;
    logic precharge_all_command_clear;

    // ==================== access sequencer state
    sbd_state_type st_r, st_nxt, after_r, after_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [3:0] beats_r, beats_nxt;
    logic burst_r, burst_nxt;
    logic wr_r, wr_nxt;
    logic [31:0] addr_r, addr_nxt;
    logic open_r, open_nxt;
    logic [31-PAGE_LSB:0] open_pg_r, open_pg_nxt;
    sbd_sdcmd_type cmd_r, cmd_nxt;
    logic done_r, done_nxt, hit_r, hit_nxt, aexc_r, aexc_nxt;
    logic csreq_r, csreq_nxt, ext_r, ext_nxt, acc_r, acc_nxt, rdy_r, rdy_nxt;

    // ==================== hit decode
    logic [BASE_W-1:0] addr_diff;
    logic [AM_W-1:0] am_bits;
    logic base_match, type_ok, ps_ok, hit;
    logic [31:0] last_byte;
    logic in_page;

    // masked base-address compare, one bit per address line
    genvar g;
    generate
        for (g = 0; g < BASE_W; g++) begin : g_cmp
            assign addr_diff[g] = (i_req_data.addr[BASE_LSB+g] ^ ctrl_r[BASE_LSB+g])
                                  & ~mask_r[BAM_LSB+g];
        end
    endgenerate

    always_comb begin
        am_bits = mask_r[AM_LSB +: AM_W];
        base_match = (addr_diff == '0);
        // category index selects its mask bit
        type_ok = (i_req_data.cat < 3'(AM_W)) && !am_bits[i_req_data.cat];
        // only the 16-bit port setting is accepted
        ps_ok = ctrl_r[PS_WIDE_BIT];
        // full hit condition, gated by block enable
        hit = mask_r[VALID_BIT] && base_match && type_ok && ps_ok;
        last_byte = i_req_data.addr + 32'(i_req_data.bytes) - 32'h0000_0001;
        in_page = (last_byte[31:PAGE_LSB] == i_req_data.addr[31:PAGE_LSB]);
    end

    // ==================== sequencer next state
    always_comb begin
        st_nxt = st_r;
        after_nxt = after_r;
        cnt_nxt = cnt_r;
        beats_nxt = beats_r;
        burst_nxt = burst_r;
        wr_nxt = wr_r;
        addr_nxt = addr_r;
        open_nxt = open_r;
        open_pg_nxt = open_pg_r;
        cmd_nxt = SD_NOP;
        done_nxt = 1'b0;
        hit_nxt = hit_r;
        aexc_nxt = 1'b0;
        csreq_nxt = 1'b0;
        ext_nxt = ext_r;
        acc_nxt = 1'b0;
        precharge_all_command_clear = 1'b0;
        ev = '0;
        unique case (st_r)
            ST_IDLE: begin
                if (i_req) begin
                    hit_nxt = hit;
                    addr_nxt = i_req_data.addr;
                    wr_nxt = i_req_data.write;
                    if (!ps_ok && mask_r[VALID_BIT]) begin
                        ev[IRQ_BAD_PS] = 1'b1;
                    end
                    if (!hit) begin
                        st_nxt = ST_FIN;
                    end else if (i_req_data.write && mask_r[WP_BIT]) begin
                        aexc_nxt = 1'b1;
                        ev[IRQ_WP_EXC] = 1'b1;
                        // pass the write on to chip-select decode
                        csreq_nxt = 1'b1;
                        st_nxt = ST_CS_WAIT;
                    end else if (i_req_data.write && ctrl_r[TRIG_BIT]) begin
                        // armed trigger makes this write a precharge-all
                        st_nxt = ST_PRECHARGE_ALL_COMMAND;
                    end else begin
                        // burst only inside one page and above port size
                        burst_nxt = in_page && (i_req_data.bytes > 5'(PORT_BYTES));
                        beats_nxt = (i_req_data.bytes > 5'(PORT_BYTES))
                                    ? 4'(i_req_data.bytes >> 1) : 4'h1;
                        if (open_r && open_pg_r == i_req_data.addr[31:PAGE_LSB]) begin
                            // open page hit goes straight to column strobe
                            st_nxt = ST_COL;
                        end else if (open_r) begin
                            st_nxt = ST_PRE;
                        end else begin
                            st_nxt = ST_ACT;
                        end
                    end
                end
            end
            ST_PRE: begin
                cmd_nxt = '{1'b0, 1'b0, 1'b1, 1'b0, '0};
                open_nxt = 1'b0;
                cnt_nxt = CNT_W'(TRP_CYC);
                after_nxt = (beats_r == '0) ? ST_FIN : ST_ACT;
                st_nxt = ST_WAIT;
            end
            ST_ACT: begin
                cmd_nxt = '{1'b0, 1'b0, 1'b1, 1'b1, addr_r[PAGE_LSB +: ROW_W]};
                open_nxt = 1'b1;
                open_pg_nxt = addr_r[31:PAGE_LSB];
                cnt_nxt = CNT_W'(TRCD_CYC);
                after_nxt = ST_COL;
                st_nxt = ST_WAIT;
            end
            ST_COL: begin
                // column strobe only, row stays as opened
                cmd_nxt = '{1'b0, 1'b1, 1'b0, !wr_r, ROW_W'(addr_r[PAGE_LSB-1:1])};
                beats_nxt = beats_r - 4'h1;
                addr_nxt = addr_r + 32'(PORT_BYTES);
                if (beats_r != 4'h1) begin
                    // in page mode 0 a non-burst transfer closes and reopens between beats
                    st_nxt = (burst_r || ctrl_r[PM_BIT]) ? ST_COL : ST_PRE;
                    if (ctrl_r[PM_BIT]
                        && addr_nxt[31:PAGE_LSB] != open_pg_r) begin
                        st_nxt = ST_PRE;
                    end
                end else begin
                    // page mode 0 closes the page after the transfer
                    st_nxt = ctrl_r[PM_BIT] ? ST_FIN : ST_PRE;
                end
            end
            ST_WAIT: begin
                cnt_nxt = cnt_r - CNT_W'(1);
                if (cnt_r == CNT_W'(1)) begin
                    st_nxt = after_r;
                end
            end
            ST_PRECHARGE_ALL_COMMAND: begin
                // precharge-all: address line 10 high on a precharge
                cmd_nxt = '{1'b0, 1'b0, 1'b1, 1'b0, ROW_W'(13'h0400)};
                open_nxt = 1'b0;
                beats_nxt = '0;
                cnt_nxt = CNT_W'(TRP_CYC);
                after_nxt = ST_FIN;
                precharge_all_command_clear = 1'b1;
                st_nxt = ST_WAIT;
            end
            ST_CS_WAIT: begin
                // no chip select claimed it: run an external cycle
                if (i_cs_valid) begin
                    st_nxt = i_cs_hit ? ST_FIN : ST_EXT;
                    ext_nxt = !i_cs_hit;
                    cnt_nxt = CNT_W'(EXT_TIMEOUT_CYC);
                end
            end
            ST_EXT: begin
                cnt_nxt = cnt_r - CNT_W'(1);
                if (i_ext_ack) begin
                    ext_nxt = 1'b0;
                    st_nxt = ST_FIN;
                end else if (cnt_r == CNT_W'(1)) begin
                    // missing acknowledge ends in an access exception
                    ext_nxt = 1'b0;
                    acc_nxt = 1'b1;
                    ev[IRQ_ACC_EXC] = 1'b1;
                    st_nxt = ST_FIN;
                end
            end
            ST_FIN: begin
                done_nxt = 1'b1;
                st_nxt = ST_IDLE;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
        rdy_nxt = (st_nxt == ST_IDLE);
    end

    // ==================== sequencer registers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= ST_IDLE;
            after_r <= ST_IDLE;
            cnt_r <= '0;
            beats_r <= '0;
            burst_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= '0;
            open_r <= 1'b0;
            open_pg_r <= '0;
            cmd_r <= SD_NOP;
            done_r <= 1'b0;
            hit_r <= 1'b0;
            aexc_r <= 1'b0;
            csreq_r <= 1'b0;
            ext_r <= 1'b0;
            acc_r <= 1'b0;
            rdy_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            after_r <= after_nxt;
            cnt_r <= cnt_nxt;
            beats_r <= beats_nxt;
            burst_r <= burst_nxt;
            wr_r <= wr_nxt;
            addr_r <= addr_nxt;
            open_r <= open_nxt;
            open_pg_r <= open_pg_nxt;
            cmd_r <= cmd_nxt;
            done_r <= done_nxt;
            hit_r <= hit_nxt;
            aexc_r <= aexc_nxt;
            csreq_r <= csreq_nxt;
            ext_r <= ext_nxt;
            acc_r <= acc_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    // ==================== register file next state
    always_comb begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        ien_nxt = ien_r;
        stat_nxt = stat_r;
        rdata_nxt = '0;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                OFF_CONTROL: begin
                    ctrl_nxt[31:BASE_LSB] = i_reg_wdata[31:BASE_LSB];
                    ctrl_nxt[PS_LSB +: 2] = i_reg_wdata[PS_LSB +: 2];
                    ctrl_nxt[PM_BIT] = i_reg_wdata[PM_BIT];
                    // writing 1 arms the trigger, writing 0 leaves it
                    if (i_reg_wdata[TRIG_BIT]) begin
                        ctrl_nxt[TRIG_BIT] = 1'b1;
                    end
                end
                OFF_MASK: begin
                    mask_nxt[31:BAM_LSB] = i_reg_wdata[31:BAM_LSB];
                    mask_nxt[WP_BIT] = i_reg_wdata[WP_BIT];
                    mask_nxt[AM_LSB +: AM_W] = i_reg_wdata[AM_LSB +: AM_W];
                    mask_nxt[VALID_BIT] = i_reg_wdata[VALID_BIT];
                end
                OFF_IRQ_CLEAR: stat_nxt = stat_r & ~i_reg_wdata[IRQ_W-1:0];
                OFF_IRQ_ENABLE: ien_nxt = i_reg_wdata[IRQ_W-1:0];
                default: ;
            endcase
        end
        // trigger drops when precharge-all is issued; a new software set wins
        if (precharge_all_command_clear && !(i_reg_wr && i_reg_addr == OFF_CONTROL
                            && i_reg_wdata[TRIG_BIT])) begin
            ctrl_nxt[TRIG_BIT] = 1'b0;
        end
        // completion event and sticky status, set wins over clear
        stat_nxt = stat_nxt | ev | (IRQ_W'(precharge_all_command_clear) << IRQ_PRECHARGE_ALL_COMMAND_DONE);
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                OFF_CONTROL: rdata_nxt = ctrl_r;
                OFF_MASK: rdata_nxt = mask_r;
                OFF_IRQ_STATUS: rdata_nxt = 32'(stat_r);
                OFF_IRQ_ENABLE: rdata_nxt = 32'(ien_r);
                default: rdata_nxt = '0;
            endcase
        end
        irq_nxt = |(stat_nxt & ien_nxt);
    end

    // ==================== register file registers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_r <= CONTROL_RST;
            // block enable and all masks clear at reset
            mask_r <= MASK_RST;
            stat_r <= '0;
            ien_r <= '0;
            rdata_r <= '0;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
            stat_r <= stat_nxt;
            ien_r <= ien_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    // outputs straight from flip-flops
    assign o_reg_rdata = rdata_r;
    assign o_ready = rdy_r;
    assign o_done = done_r;
    assign o_hit = hit_r;
    assign o_addr_exc = aexc_r;
    assign o_cs_req = csreq_r;
    assign o_ext_cycle = ext_r;
    assign o_access_exc = acc_r;
    assign o_sd_cmd = cmd_r;
    assign o_irq = irq_r;

endmodule : sbd_decode

// ==== sbd_decode_monitor.sv ====
// checker: port assertions of the sdram block decoder
`timescale 1ns/10ps
module sbd_decode_monitor
    import sbd_pkg::*;
(
    input wire logic i_mclk, // clock
    input wire logic i_rst, // async reset
    input wire logic [7:0] i_reg_addr, // register address
    input wire logic [31:0] i_reg_wdata, // register write data
    input wire logic i_reg_wr, // register write strobe
    input wire logic i_req, // access request
    input wire sbd_pkg::sbd_req_type i_req_data, // request fields
    input wire logic o_ready, // idle
    input wire logic o_hit, // hit result
    input wire logic o_addr_exc, // address exception
    input wire logic o_cs_req, // chip-select handoff
    input wire logic o_ext_cycle, // external cycle
    input wire logic i_ext_ack, // external ack
    input wire logic o_access_exc, // access exception
    input wire sbd_pkg::sbd_sdcmd_type o_sd_cmd // sdram command
);
    logic [31:0] ctl_r, ctl_nxt, msk_r, msk_nxt;
    logic [21:0] pg_r, pg_nxt;
    logic open_r, open_nxt, take, hit_calc, sp, is_act, is_col, is_pre, is_precharge_all_command;
    logic [3:0] c;

    // shadows and expected decode
    always_comb begin
        c = o_sd_cmd[ROW_W+3:ROW_W];
        is_act = (c == 4'h3);
        is_col = (c[3:1] == 3'h2);
        is_pre = (c == 4'h2);
        is_precharge_all_command = is_pre && o_sd_cmd.addr[10];
        take = i_req && o_ready;
        hit_calc = msk_r[VALID_BIT] && ctl_r[PS_WIDE_BIT] && (i_req_data.cat < 3'h6)
            && ((((i_req_data.addr ^ ctl_r) & ~msk_r) >> BAM_LSB) == 32'h0)
            && !msk_r[i_req_data.cat + 1];
        sp = take && hit_calc && ctl_r[PM_BIT] && open_r && (pg_r == i_req_data.addr[31:10])
            && !(i_req_data.write && (msk_r[WP_BIT] || ctl_r[TRIG_BIT]));
        ctl_nxt = (i_reg_wr && i_reg_addr == OFF_CONTROL) ? i_reg_wdata : ctl_r;
        msk_nxt = (i_reg_wr && i_reg_addr == OFF_MASK) ? i_reg_wdata : msk_r;
        open_nxt = is_act ? 1'b1 : (is_pre ? 1'b0 : open_r);
        pg_nxt = (take && hit_calc) ? i_req_data.addr[31:10] : pg_r;
    end

    // register the helper state
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ctl_r <= '0;
            msk_r <= '0;
            open_r <= 1'b0;
            pg_r <= '0;
        end else begin
            ctl_r <= ctl_nxt;
            msk_r <= msk_nxt;
            open_r <= open_nxt;
            pg_r <= pg_nxt;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // ==================== sequences and properties
    sequence s_nop3;
        (o_sd_cmd == SD_NOP) [*3];
    endsequence
    sequence s_close;
        is_col || is_pre;
    endsequence
    property p_hit_decode; $past(take) |-> o_hit == $past(hit_calc); endproperty
    property p_off_nohit; $past(take && !msk_r[VALID_BIT]) |-> !o_hit; endproperty
    property p_ps_nohit; $past(take && !ctl_r[PS_WIDE_BIT]) |-> !o_hit; endproperty
    property p_wp_exc;
        o_addr_exc |-> o_cs_req && $past(take && hit_calc && i_req_data.write && msk_r[WP_BIT]);
    endproperty
    property p_wp_quiet; o_addr_exc |-> s_nop3; endproperty
    property p_ext_bound; $rose(o_ext_cycle) |-> ##[1:130] !o_ext_cycle; endproperty
    property p_acc_exc; o_access_exc |-> $past(o_ext_cycle) && !$past(i_ext_ack); endproperty
    property p_precharge_all_command; is_precharge_all_command |-> $past(take && i_req_data.write, 2) && o_hit; endproperty
    property p_col_open; is_col |-> open_r; endproperty
    property p_pm0_close; is_col && !ctl_r[PM_BIT] |=> s_close; endproperty
    property p_open_page; $past(sp, 2) |-> is_col; endproperty

    a_hit_decode: assert property (p_hit_decode) else $error("hit decode wrong");
    a_off_nohit: assert property (p_off_nohit) else $error("disabled block hit");
    a_ps_nohit: assert property (p_ps_nohit) else $error("bad port size hit");
    a_wp_exc: assert property (p_wp_exc) else $error("addr exc wrong");
    a_wp_quiet: assert property (p_wp_quiet) else $error("wp write hit sdram");
    a_ext_bound: assert property (p_ext_bound) else $error("external cycle hung");
    a_acc_exc: assert property (p_acc_exc) else $error("acc exc wrong");
    a_precharge_all_command: assert property (p_precharge_all_command) else $error("stray precharge_all_command");
    a_col_open: assert property (p_col_open) else $error("column on closed row");
    a_pm0_close: assert property (p_pm0_close) else $error("page left open");
    a_open_page: assert property (p_open_page) else $error("page not reused");
endmodule : sbd_decode_monitor

bind sbd_decode sbd_decode_monitor u_mon (.i_mclk, .i_rst, .i_reg_addr, .i_reg_wdata,
    .i_reg_wr, .i_req, .i_req_data, .o_ready, .o_hit, .o_addr_exc, .o_cs_req, .o_ext_cycle,
    .i_ext_ack, .o_access_exc, .o_sd_cmd);

// ==== sbd_sdram_model.sv ====
// model: sdram command counter and row checker
`timescale 1ns/10ps
module sbd_sdram_model
    import sbd_pkg::*;
(
    input wire logic i_mclk, // clock
    input wire logic i_rst, // async reset
    input wire sbd_pkg::sbd_sdcmd_type i_cmd, // command lines
    output logic [31:0] o_cnts, // act, column, pre, precharge_all_command counts
    output logic o_err // column to a closed row
);
    logic open_r;

    // track the open row; columns need one
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_cnts <= '0;
            open_r <= 1'b0;
            o_err <= 1'b0;
        end else if (i_cmd[ROW_W+3:ROW_W] == 4'h3) begin
            o_cnts <= o_cnts + 32'h0100_0000;
            open_r <= 1'b1;
        end else if (i_cmd[ROW_W+3:ROW_W-0] == 4'h2) begin
            o_cnts <= o_cnts + (i_cmd.addr[10] ? 32'h1 : 32'h100);
            open_r <= 1'b0;
        end else if (i_cmd[ROW_W+3:ROW_W+1] == 3'h2) begin
            o_cnts <= o_cnts + 32'h1_0000;
            o_err <= o_err | !open_r;
        end
    end
endmodule : sbd_sdram_model

// ==== sbd_decode_tb.sv ====
// testbench: register, decode, page mode, precharge-all and protection tests
`timescale 1ns/10ps
module sbd_decode_tb;
    import sbd_pkg::*;
    logic i_mclk, i_rst, i_reg_wr, i_reg_rd, i_req, i_cs_valid, i_cs_hit, i_ext_ack;
    logic o_ready, o_done, o_hit, o_addr_exc, o_cs_req, o_ext_cycle, o_access_exc, o_irq;
    logic o_err, ack_en, seen_ae, seen_ax;
    logic [7:0] i_reg_addr;
    logic [31:0] i_reg_wdata, o_reg_rdata, o_cnts, base;
    sbd_req_type i_req_data;
    sbd_sdcmd_type o_sd_cmd;
    int errors, n_tests, cyc, c;

    sbd_decode dut (.i_mclk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
        .o_reg_rdata, .i_req, .i_req_data, .o_ready, .o_done, .o_hit, .o_addr_exc, .o_cs_req,
        .i_cs_valid, .i_cs_hit, .o_ext_cycle, .i_ext_ack, .o_access_exc, .o_sd_cmd, .o_irq);
    sbd_sdram_model u_sdram (.i_mclk, .i_rst, .i_cmd(o_sd_cmd), .o_cnts, .o_err);

    // clock, 10 ns period
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // external ack when enabled
    always @(posedge i_mclk) begin
        i_ext_ack <= ack_en && o_ext_cycle;
    end

    // ==================== tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge i_mclk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        @(negedge i_mclk);
        chk(o_reg_rdata, exp, what);
    endtask : rd
    task automatic req(input logic [31:0] a, input logic w, input logic [4:0] nb,
        input logic [2:0] cat, input logic exp_hit);
        @(posedge i_mclk);
        i_req <= 1'b1;
        i_req_data <= '{a, w, nb, cat};
        @(posedge i_mclk);
        i_req <= 1'b0;
        {seen_ae, seen_ax} = '0;
        for (int k = 0; k < 300; k++) begin
            @(negedge i_mclk);
            seen_ae |= o_addr_exc;
            seen_ax |= o_access_exc;
            if (o_done === 1'b1) break;
        end
        chk(o_hit, exp_hit, "hit");
    endtask : req
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    // cut a hang short
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            conclude();
        end
    end

    // ==================== main sequence
    initial begin
        {errors, n_tests, cyc} = '0;
        {i_rst, i_cs_valid} = 2'h3;
        {i_reg_wr, i_reg_rd, i_req, i_cs_hit, i_ext_ack, ack_en} = '0;
        i_reg_addr = '0;
        i_reg_wdata = '0;
        i_req_data = '0;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(OFF_CONTROL, 32'h0, "ctrl rst");
        rd(OFF_MASK, 32'h0, "mask rst");
        rd(8'h14, 32'h0, "unmapped");
        req(32'h0, 1'b0, 5'd2, CAT_USER_DATA, 1'b0);
        wr(OFF_MASK, 32'h1);
        req(32'h0, 1'b0, 5'd2, CAT_USER_DATA, 1'b0);
        rd(OFF_IRQ_STATUS, 32'h8, "bad ps");
        wr(OFF_IRQ_CLEAR, 32'hf);
        rd(OFF_IRQ_STATUS, 32'h0, "status cleared");
        $display("test reset done");
        // base 0x0040_0000, bit 20 and supv data masked
        wr(OFF_CONTROL, 32'h0040_0020);
        wr(OFF_MASK, 32'h0010_0009);
        rd(OFF_MASK, 32'h0010_0009, "mask rb");
        for (c = 0; c < 8; c++) req(32'h0040_0000, 1'b0, 5'd2, c[2:0], c < 6 && c != 2);
        req(32'h0050_0000, 1'b0, 5'd2, CAT_USER_DATA, 1'b1);
        req(32'h0048_0000, 1'b0, 5'd2, CAT_USER_DATA, 1'b0);
        $display("test decode done");
        base = o_cnts;
        req(32'h0040_0100, 1'b0, 5'd8, CAT_USER_DATA, 1'b1);
        chk(o_cnts - base, 32'h0104_0100, "in page");
        base = o_cnts;
        req(32'h0040_03f8, 1'b0, 5'd16, CAT_USER_DATA, 1'b1);
        chk(o_cnts - base, 32'h0808_0800, "cross page");
        $display("test page mode 0 done");
        wr(OFF_CONTROL, 32'h0040_0024);
        base = o_cnts;
        req(32'h0040_0800, 1'b0, 5'd2, CAT_USER_DATA, 1'b1);
        req(32'h0040_0802, 1'b1, 5'd2, CAT_USER_DATA, 1'b1);
        req(32'h0040_0c00, 1'b0, 5'd2, CAT_USER_DATA, 1'b1);
        chk(o_cnts - base, 32'h0203_0100, "open page");
        $display("test page mode 1 done");
        wr(OFF_CONTROL, 32'h0040_002c);
        base = o_cnts;
        req(32'h0040_0000, 1'b1, 5'd2, CAT_USER_DATA, 1'b1);
        chk(o_cnts - base, 32'h0000_0001, "precharge_all_command");
        rd(OFF_CONTROL, 32'h0040_0024, "trig clr");
        rd(OFF_IRQ_STATUS, 32'h4, "precharge_all_command status");
        wr(OFF_IRQ_ENABLE, 32'h4);
        rd(OFF_IRQ_ENABLE, 32'h4, "ien rb");
        chk(o_irq, 1'b1, "irq on");
        wr(OFF_IRQ_CLEAR, 32'h4);
        rd(OFF_IRQ_STATUS, 32'h0, "status cleared");
        chk(o_irq, 1'b0, "irq off");
        $display("test precharge_all_command done");
        wr(OFF_MASK, 32'h0010_0109);
        i_cs_hit = 1'b1;
        base = o_cnts;
        req(32'h0040_0000, 1'b1, 5'd2, CAT_USER_DATA, 1'b1);
        chk(seen_ae, 1'b1, "addr exc");
        chk(o_cnts - base, 32'h0, "wp quiet");
        chk(o_irq, 1'b0, "irq masked");
        rd(OFF_IRQ_STATUS, 32'h1, "wp status");
        i_cs_hit = 1'b0;
        ack_en = 1'b1;
        req(32'h0040_0000, 1'b1, 5'd2, CAT_USER_DATA, 1'b1);
        chk(seen_ax, 1'b0, "ack");
        ack_en = 1'b0;
        req(32'h0040_0000, 1'b1, 5'd2, CAT_USER_DATA, 1'b1);
        chk(seen_ax, 1'b1, "no ack");
        rd(OFF_IRQ_STATUS, 32'h3, "ax status");
        wr(OFF_IRQ_ENABLE, 32'h1);
        rd(OFF_IRQ_ENABLE, 32'h1, "ien rb");
        chk(o_irq, 1'b1, "irq on wp");
        chk(o_err, 1'b0, "rows");
        $display("test write protect done");
        conclude();
    end
endmodule : sbd_decode_tb
